// ### rtl/charge_ctrl_pkg.sv
// Constants, types and encodings for the charge-control state machine.
// Assumes a single 10 MHz clock and an AHB-Lite master with 32-bit data.
`default_nettype none

package charge_ctrl_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned TEMP_DEGL_MS      = 375;
  localparam logic [31:0] TEMP_DEGL_CYCLES  = 32'(TEMP_DEGL_MS * (CLK_HZ / 1000));
  localparam logic [31:0] PRECHG_CYCLES     = 32'h000F_4240;
  localparam logic [31:0] FAST_CYCLES       = 32'h0098_9680;
  localparam logic [31:0] TERM_DEGL_CYCLES  = 32'h0000_03E8;

  // Register map (byte addresses, one word each)
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
  localparam logic        CTRL_INHIBIT_RST  = 1'b0;
  localparam int unsigned CTRL_INHIBIT_BIT  = 0;
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_PROBE_BIT    = 4;
  localparam int unsigned STAT_TEMP_BIT     = 5;
  localparam int unsigned STAT_ARMED_BIT    = 6;

  // Sense inputs from the analog comparators and pins
  typedef struct packed {
    logic supply_present;
    logic charge_enable_n;
    logic timer_allow_n;
    logic above_precharge;
    logic at_regulation;
    logic above_recharge;
    logic below_term_current;
    logic temp_in_window;
  } sense_t;

  localparam sense_t SENSE_RST = '{supply_present: 1'b0, charge_enable_n: 1'b1, timer_allow_n: 1'b1,
                                   above_precharge: 1'b0, at_regulation: 1'b0, above_recharge: 1'b0,
                                   below_term_current: 1'b0, temp_in_window: 1'b1};

  typedef enum logic [3:0] {
    ST_SLEEP    = 4'h0,
    ST_DISABLED = 4'h1,
    ST_PRECHG   = 4'h2,
    ST_FAST_CC  = 4'h3,
    ST_VOLT_REG = 4'h4,
    ST_TERM_WT  = 4'h5,
    ST_DONE     = 4'h6,
    ST_SUSPEND  = 4'h7,
    ST_FAULT    = 4'h8
  } chg_state_t;

endpackage : charge_ctrl_pkg

`default_nettype wire

// ### rtl/li_ion_charge_control_fsm.sv
// Charge sequencer: precharge, constant current, voltage regulation, termination,
// recharge, temperature suspend, sleep and timer-fault recovery, plus an AHB-Lite slave.
// Assumes comparator and pin inputs are asynchronous; open-drain pads resolve outside.
`timescale 1ns/1ps
`default_nettype none

module li_ion_charge_control_fsm #(
  parameter logic [31:0] PRECHG_LEN = charge_ctrl_pkg::PRECHG_CYCLES,
  parameter logic [31:0] FAST_LEN   = charge_ctrl_pkg::FAST_CYCLES,
  parameter logic [31:0] TERM_LEN   = charge_ctrl_pkg::TERM_DEGL_CYCLES,
  parameter logic [31:0] TEMP_LEN   = charge_ctrl_pkg::TEMP_DEGL_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  // Comparator and pin inputs
  input  wire charge_ctrl_pkg::sense_t sense_in,
  // AHB-Lite slave
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic [31:0]                  hrdata_out,
  output logic                         hreadyout_out,
  output logic                         hresp_out,
  // Open-drain status and supply-good pads
  output logic                         status_out_a_out,
  output logic                         status_out_a_oe_out,
  output logic                         status_out_b_out,
  output logic                         status_out_b_oe_out,
  output logic                         supply_good_n_out,
  output logic                         supply_good_n_oe_out,
  // Power path controls
  output logic                         pass_switch_on_out,
  output logic                         precharge_mode_out,
  output logic                         removal_probe_current_out
);
  import charge_ctrl_pkg::*;

  function automatic logic [7:0] reg_offset(input logic [31:0] addr);
    reg_offset = (addr[31:8] == 24'h00_0000) ? {addr[7:2], 2'b00} : 8'hFF;
  endfunction : reg_offset

  function automatic logic is_charging(input chg_state_t st);
    is_charging = (st == ST_PRECHG) || (st == ST_FAST_CC) || (st == ST_VOLT_REG);
  endfunction : is_charging

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a change counts once stages two and three agree
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  sense_t     cmp_q;
  sense_t     prev_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s1_q   <= SENSE_RST;
      s2_q   <= SENSE_RST;
      s3_q   <= SENSE_RST;
      cmp_q  <= SENSE_RST;
      prev_q <= SENSE_RST;
    end else begin
      s1_q   <= sense_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      cmp_q  <= sense_t'((s2_q & ~(s2_q ^ s3_q)) | (cmp_q & (s2_q ^ s3_q)));
      prev_q <= cmp_q;
    end
  end

  logic ce_fall;
  logic te_toggle;
  logic ce_toggle;
  assign ce_fall   = prev_q.charge_enable_n & ~cmp_q.charge_enable_n;
  assign ce_toggle = prev_q.charge_enable_n ^ cmp_q.charge_enable_n;
  assign te_toggle = prev_q.timer_allow_n ^ cmp_q.timer_allow_n;

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic        inhibit_q;
  logic        wr_pend_q;
  logic [7:0]  wr_off_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        addr_phase;
  logic [31:0] status_word;
  chg_state_t  state_q;
  chg_state_t  state_d;
  logic        temp_bad_q;
  logic        armed_q;
  logic        probe_q;

  assign addr_phase  = hsel_in & hready_in & htrans_in[1];
  assign status_word = {25'h000_0000, armed_q, temp_bad_q, probe_q, state_q};

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase & hwrite_in;
      wr_off_q  <= reg_offset(haddr_in);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      inhibit_q <= CTRL_INHIBIT_RST;
    end else if (wr_pend_q && wr_off_q == CTRL_OFFSET) begin
      inhibit_q <= hwdata_in[CTRL_INHIBIT_BIT];
    end
  end

  // Read data is fetched in the address phase so it stands in the data phase
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (addr_phase && !hwrite_in) begin
        case (reg_offset(haddr_in))
          CTRL_OFFSET:   hrdata_q <= {31'h0000_0000, inhibit_q};
          STATUS_OFFSET: hrdata_q <= status_word;
          default:       hrdata_q <= 32'h0000_0000;
        endcase
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature fault deglitch
  logic [31:0] temp_cnt_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      temp_cnt_q <= 32'h0000_0000;
      temp_bad_q <= 1'b0;
    end else if (cmp_q.temp_in_window) begin
      temp_cnt_q <= 32'h0000_0000;
      temp_bad_q <= 1'b0;
    end else begin
      if (temp_cnt_q != TEMP_LEN - 32'h0000_0001) begin
        temp_cnt_q <= temp_cnt_q + 32'h0000_0001;
      end
      temp_bad_q <= (temp_cnt_q == TEMP_LEN - 32'h0000_0001);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Safety timers and termination deglitch
  logic [31:0] pre_cnt_q;
  logic [31:0] fast_cnt_q;
  logic [31:0] term_cnt_q;
  logic        pre_exp;
  logic        fast_exp;
  logic        term_exp;
  logic        restart;
  logic        timer_clr;
  assign pre_exp   = (pre_cnt_q == PRECHG_LEN - 32'h0000_0001);
  assign fast_exp  = ~cmp_q.timer_allow_n & (fast_cnt_q == FAST_LEN - 32'h0000_0001);
  assign term_exp  = (term_cnt_q == TERM_LEN - 32'h0000_0001);
  assign timer_clr = ce_fall | restart;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pre_cnt_q <= 32'h0000_0000;
    end else if (timer_clr) begin
      pre_cnt_q <= 32'h0000_0000;
    end else if (state_q == ST_PRECHG && !pre_exp) begin
      pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
    end
  end

  // Held while suspended or while the timer is disallowed
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fast_cnt_q <= 32'h0000_0000;
    end else if (timer_clr) begin
      fast_cnt_q <= 32'h0000_0000;
    end else if ((state_q == ST_FAST_CC || state_q == ST_VOLT_REG) && !cmp_q.timer_allow_n && !fast_exp) begin
      fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      term_cnt_q <= 32'h0000_0000;
    end else if (state_q != ST_TERM_WT) begin
      term_cnt_q <= 32'h0000_0000;
    end else if (!term_exp) begin
      term_cnt_q <= term_cnt_q + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Charge sequencer
  chg_state_t held_q;
  chg_state_t start_state;
  logic       enabled;
  logic       fault_clear;
  logic       armed_d;
  assign enabled     = cmp_q.supply_present & ~cmp_q.charge_enable_n & ~inhibit_q;
  assign start_state = cmp_q.above_precharge ? ST_FAST_CC : ST_PRECHG;
  assign fault_clear = ce_toggle | te_toggle;

  always_comb begin
    state_d = state_q;
    restart = 1'b0;
    if (!cmp_q.supply_present) begin
      state_d = ST_SLEEP;
    end else if (!enabled) begin
      state_d = ST_DISABLED;
    end else begin
      case (state_q)
        ST_SLEEP, ST_DISABLED: begin
          state_d = start_state;
          restart = 1'b1;
        end
        ST_PRECHG: begin
          if (temp_bad_q) begin
            state_d = ST_SUSPEND;
          end else if (cmp_q.above_precharge) begin
            state_d = ST_FAST_CC;
          end else if (pre_exp) begin
            state_d = ST_FAULT;
          end
        end
        ST_FAST_CC: begin
          if (temp_bad_q) begin
            state_d = ST_SUSPEND;
          end else if (fast_exp) begin
            state_d = ST_FAULT;
          end else if (cmp_q.at_regulation) begin
            state_d = ST_VOLT_REG;
          end
        end
        ST_VOLT_REG: begin
          if (temp_bad_q) begin
            state_d = ST_SUSPEND;
          end else if (fast_exp) begin
            state_d = ST_FAULT;
          end else if (cmp_q.below_term_current) begin
            state_d = ST_TERM_WT;
          end
        end
        ST_TERM_WT: begin
          if (term_exp) begin
            state_d = ST_DONE;
          end
        end
        ST_DONE: begin
          if (!cmp_q.above_recharge) begin
            state_d = start_state;
            restart = 1'b1;
          end
        end
        ST_SUSPEND: begin
          if (!temp_bad_q) begin
            state_d = held_q;
          end
        end
        ST_FAULT: begin
          if (fault_clear || (armed_q && !cmp_q.above_recharge)) begin
            state_d = start_state;
            restart = 1'b1;
          end
        end
        default: begin
          state_d = ST_SLEEP;
        end
      endcase
    end
  end

  // Armed once the output has stood above the recharge threshold in fault
  always_comb begin
    armed_d = (state_d == ST_FAULT) && ((state_q == ST_FAULT && armed_q) || cmp_q.above_recharge);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= ST_SLEEP;
      held_q  <= ST_PRECHG;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      armed_q <= armed_d;
      if (is_charging(state_q) && state_d == ST_SUSPEND) begin
        held_q <= state_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs, derived from the next state so they align with state_q
  logic stat_a_q;
  logic stat_b_q;
  logic pg_q;
  logic pass_q;
  logic pre_mode_q;
  logic drive_low_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stat_a_q    <= 1'b0;
      stat_b_q    <= 1'b0;
      pg_q        <= 1'b0;
      pass_q      <= 1'b0;
      pre_mode_q  <= 1'b0;
      probe_q     <= 1'b0;
      drive_low_q <= 1'b0;
    end else begin
      stat_a_q    <= (state_d == ST_PRECHG) || (state_d == ST_FAST_CC) || (state_d == ST_VOLT_REG)
                     || (state_d == ST_TERM_WT);
      stat_b_q    <= (state_d == ST_PRECHG) || (state_d == ST_DONE);
      pg_q        <= (state_d != ST_SLEEP);
      pass_q      <= is_charging(state_d);
      pre_mode_q  <= (state_d == ST_PRECHG);
      probe_q     <= (state_d == ST_FAULT) && !armed_d && !cmp_q.above_recharge;
      drive_low_q <= 1'b0;
    end
  end

  assign hrdata_out                = hrdata_q;
  assign hreadyout_out             = hreadyout_q;
  assign hresp_out                 = hresp_q;
  assign status_out_a_out          = drive_low_q;
  assign status_out_a_oe_out       = stat_a_q;
  assign status_out_b_out          = drive_low_q;
  assign status_out_b_oe_out       = stat_b_q;
  assign supply_good_n_out         = drive_low_q;
  assign supply_good_n_oe_out      = pg_q;
  assign pass_switch_on_out        = pass_q;
  assign precharge_mode_out        = pre_mode_q;
  assign removal_probe_current_out = probe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking ast_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_vreg_low_current;
    state_q == ST_VOLT_REG && enabled && !temp_bad_q && !fast_exp && cmp_q.below_term_current;
  endsequence
  sequence s_term_then_off;
    state_q == ST_TERM_WT && !pass_switch_on_out;
  endsequence
  AST_PRECHG_MODE: assert property (state_q == ST_PRECHG |-> precharge_mode_out && pass_switch_on_out)
    else $error("precharge state without precharge current");
  AST_PRECHG_FAULT: assert property ($rose(state_q == ST_FAULT) && $past(state_q) == ST_PRECHG
                                     |-> $past(pre_cnt_q) == PRECHG_LEN - 32'h0000_0001)
    else $error("precharge fault before timer expiry");
  AST_TO_VREG: assert property (state_q == ST_FAST_CC && enabled && !temp_bad_q && !fast_exp && cmp_q.at_regulation
                                |=> state_q == ST_VOLT_REG)
    else $error("regulation threshold did not start voltage regulation");
  AST_FAST_FAULT: assert property ($rose(state_q == ST_FAULT) && $past(state_q) != ST_PRECHG && !$past(fault_clear)
                                   |-> $past(fast_cnt_q) == FAST_LEN - 32'h0000_0001 && !$past(cmp_q.timer_allow_n))
    else $error("fast-charge fault without timer expiry");
  AST_TERMINATE: assert property (s_vreg_low_current |=> s_term_then_off)
    else $error("termination did not stop charging at once");
  AST_DONE_DEGLITCH: assert property ($rose(state_q == ST_DONE)
                                      |-> $past(state_q) == ST_TERM_WT && $past(term_cnt_q) == TERM_LEN - 32'h0000_0001)
    else $error("charge done declared before deglitch expiry");
  AST_RECHARGE: assert property (state_q == ST_DONE && enabled && !cmp_q.above_recharge
                                 |=> is_charging(state_q) && pre_cnt_q == 32'h0000_0000)
    else $error("no recharge below recharge threshold");
  AST_SLEEP: assert property (!cmp_q.supply_present |=> state_q == ST_SLEEP && !supply_good_n_oe_out)
    else $error("no sleep without input supply");
  AST_STATUS_CODE: assert property (status_out_a_oe_out && status_out_b_oe_out |-> state_q == ST_PRECHG)
    else $error("status code on/on outside precharge");
  AST_CE_RESET: assert property ($fell(cmp_q.charge_enable_n) |=> pre_cnt_q == 32'h0000_0000
                                 && fast_cnt_q == 32'h0000_0000 && state_q != ST_FAULT)
    else $error("charge enable fall did not reset timers");
  AST_SUSPEND_HOLD: assert property (state_q == ST_SUSPEND && $past(state_q) == ST_SUSPEND
                                     |-> $stable(fast_cnt_q) && $stable(pre_cnt_q) && !pass_switch_on_out)
    else $error("timers moved or switch on during suspend");
  AST_RESUME: assert property (state_q == ST_SUSPEND && enabled && !temp_bad_q |=> state_q == $past(held_q))
    else $error("no resume to held state");
  AST_TEMP_QUAL: assert property ($rose(temp_bad_q) |-> $past(temp_cnt_q) == TEMP_LEN - 32'h0000_0001)
    else $error("temperature fault taken before deglitch");
  AST_PROBE: assert property (state_q == ST_FAULT && !armed_q && !cmp_q.above_recharge && enabled && !fault_clear
                              |=> removal_probe_current_out)
    else $error("probe current missing in fault");
  AST_PROBE_OFF: assert property (removal_probe_current_out |-> state_q == ST_FAULT && !armed_q)
    else $error("probe current on while armed or outside fault");

endmodule : li_ion_charge_control_fsm

`default_nettype wire

// ### testbench/charge_sense_model.sv
// Far-side model: battery comparators, thermistor window and status pull-ups.
// Assumes the bench sets the analog levels and the charger drives the pad enables.
`timescale 1ns/1ps
`default_nettype none

module charge_sense_model (
  // Analog levels set by the bench
  input  wire logic                   supply_in,
  input  wire logic                   enable_n_in,
  input  wire logic                   tmr_n_in,
  input  wire logic [1:0]             vbat_in,
  input  wire logic                   recharge_hi_in,
  input  wire logic                   low_current_in,
  input  wire logic                   temp_ok_in,
  // Pad enables from the charger
  input  wire logic                   a_oe_in,
  input  wire logic                   b_oe_in,
  input  wire logic                   good_oe_in,
  // Comparator outputs and resolved pad levels
  output var charge_ctrl_pkg::sense_t sense_out,
  output logic [2:0]                  pins_out
);
  import charge_ctrl_pkg::*;

  // Battery level: 0 below precharge exit, 1 constant current, 2 at regulation
  always_comb begin
    sense_out.supply_present     = supply_in;
    sense_out.charge_enable_n    = enable_n_in;
    sense_out.timer_allow_n      = tmr_n_in;
    sense_out.above_precharge    = (vbat_in != 2'h0);
    sense_out.at_regulation      = (vbat_in == 2'h2);
    sense_out.above_recharge     = recharge_hi_in;
    sense_out.below_term_current = low_current_in;
    sense_out.temp_in_window     = temp_ok_in;
  end

  // Released open-drain pads float up to their pull-ups
  assign pins_out = {~a_oe_in, ~b_oe_in, ~good_oe_in};

endmodule : charge_sense_model

`default_nettype wire

// ### testbench/li_ion_charge_control_fsm_tb.sv
// Self-checking bench for the charge sequencer.
// Assumes the sense model feeds sense_in and resolves the open-drain pads.
`timescale 1ns/1ps
`default_nettype none

module li_ion_charge_control_fsm_tb;
  import charge_ctrl_pkg::*;

  // Pad levels a, b, good, then pass, precharge mode, probe
  localparam logic [5:0] PRE = 6'h06, FST = 6'h14, TRM = 6'h10, DN = 6'h20;
  localparam logic [5:0] OFF = 6'h30, PRB = 6'h31, SLP = 6'h38;

  logic        clk = 1'b0, rst = 1'b1, sup = 1'b0, ce_n = 1'b1, tmr_n = 1'b0;
  logic        rch = 1'b0, term = 1'b0, tok = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  vbat = 2'h0, htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hrdy, hresp, a_oe, b_oe, good_oe, pass, pre, prb;
  logic [2:0]  pins, pad_d;
  logic [5:0]  outv;
  sense_t      sense;
  int          num_errors = 0, checks_done = 0, cycles = 0;

  assign outv = {pins, pass, pre, prb};
  always #50 clk = ~clk;

  li_ion_charge_control_fsm #(.PRECHG_LEN(32'h14), .FAST_LEN(32'h28), .TERM_LEN(32'h5), .TEMP_LEN(32'h8)) i_dut (
    .ref_clk_in(clk), .rst_in(rst), .sense_in(sense), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .status_out_a_out(pad_d[2]),
    .status_out_a_oe_out(a_oe), .status_out_b_out(pad_d[1]), .status_out_b_oe_out(b_oe),
    .supply_good_n_out(pad_d[0]),
    .supply_good_n_oe_out(good_oe), .pass_switch_on_out(pass), .precharge_mode_out(pre),
    .removal_probe_current_out(prb));

  charge_sense_model i_model (
    .supply_in(sup), .enable_n_in(ce_n), .tmr_n_in(tmr_n), .vbat_in(vbat), .recharge_hi_in(rch),
    .low_current_in(term), .temp_ok_in(tok), .a_oe_in(a_oe), .b_oe_in(b_oe), .good_oe_in(good_oe),
    .sense_out(sense), .pins_out(pins));

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wait_out(input logic [5:0] exp, input int lim, input string msg);
    int n;
    n = 0;
    // Let the edge's updates settle before the first look
    #1;
    while (outv !== exp && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({26'h0, outv}, {26'h0, exp}, msg);
  endtask : wait_out

  task automatic hold(input logic [5:0] exp, input int n, input string msg);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk({26'h0, outv}, {26'h0, exp}, msg);
    end
  endtask : hold

  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask : ahb

  task automatic t_start;
    wait_out(SLP, 10, "sleep at reset");
    @(posedge clk) sup <= 1'b1;
    wait_out(OFF, 20, "disabled");
    @(posedge clk) ce_n <= 1'b0;
    wait_out(PRE, 20, "precharge");
    chk({29'h0, pad_d}, 32'h0, "pad data low");
  endtask : t_start

  task automatic t_charge;
    @(posedge clk) vbat <= 2'h1;
    wait_out(FST, 20, "fast");
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h3, "state fast");
    @(posedge clk) vbat <= 2'h2;
    rch <= 1'b1;
    hold(FST, 8, "regulation pins");
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h4, "state regulation");
    @(posedge clk) term <= 1'b1;
    wait_out(TRM, 8, "termination");
    hold(TRM, 3, "deglitch");
    wait_out(DN, 10, "done");
    @(posedge clk) term <= 1'b0;
    vbat <= 2'h1;
    rch <= 1'b0;
    wait_out(FST, 10, "recharge");
    @(posedge clk) rch <= 1'b1;
    hold(FST, 20, "fast timer run");
    wait_out(OFF, 40, "fast expiry");
    @(posedge clk) ce_n <= 1'b1;
    hold(OFF, 6, "enable high");
    @(posedge clk) ce_n <= 1'b0;
    wait_out(FST, 10, "fault cleared");
  endtask : t_charge

  task automatic t_fault;
    @(posedge clk) ce_n <= 1'b1;
    vbat <= 2'h0;
    rch <= 1'b0;
    wait_out(OFF, 10, "enable high");
    hold(OFF, 2, "disabled held");
    @(posedge clk) ce_n <= 1'b0;
    wait_out(PRE, 10, "precharge again");
    hold(PRE, 10, "precharge timer run");
    wait_out(PRB, 30, "precharge expiry, probe");
    hold(PRB, 5, "probe kept");
    @(posedge clk) rch <= 1'b1;
    wait_out(OFF, 10, "probe off");
    @(posedge clk) rch <= 1'b0;
    wait_out(PRE, 10, "fault recovery");
    wait_out(PRB, 40, "second expiry");
    @(posedge clk) tmr_n <= 1'b1;
    wait_out(PRE, 10, "timer toggle clears");
  endtask : t_fault

  task automatic t_temp;
    @(posedge clk) vbat <= 2'h1;
    wait_out(FST, 10, "fast untimed");
    hold(FST, 50, "no fast expiry");
    @(posedge clk) tok <= 1'b0;
    hold(FST, 4, "short glitch");
    @(posedge clk) tok <= 1'b1;
    hold(FST, 10, "glitch ignored");
    @(posedge clk) tok <= 1'b0;
    wait_out(OFF, 20, "suspend");
    @(posedge clk) tok <= 1'b1;
    wait_out(FST, 10, "resume");
  endtask : t_temp

  task automatic t_regs;
    ahb(1'b1, 32'h0, 32'h1);
    wait_out(OFF, 10, "inhibit");
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h1, "control readback");
    ahb(1'b1, 32'h0, 32'h0);
    wait_out(FST, 10, "inhibit released");
    ahb(1'b1, 32'h4, 32'hFF);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h3, "status read only");
    ahb(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
    @(posedge clk) sup <= 1'b0;
    wait_out(SLP, 10, "supply lost");
  endtask : t_regs

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_start();
    t_charge();
    t_fault();
    t_temp();
    t_regs();
    print_verdict();
  end

endmodule : li_ion_charge_control_fsm_tb

`default_nettype wire
